// [core/i2c_bus_status_tracker.sv]
// Summary of operation
// - With checking enabled, bits 15:8 of status two show the running check value.
// - Bit 7 reads 0 for a first-address match, 1 for a second-address match.
// - Bits 7, 6, 5, 4 clear on stop, repeated start or interface disabled.
// - Bit 6 sets on host address only with host type and resolution enabled.
// - Bit 5 sets on default device address when address resolution is enabled.
// - Bit 4 sets on general call address when general call is enabled.
// - After the address phase bit 2 takes the read/write bit as slave and its inverse as master; 1 transmits.
// - Bit 2 clears on stop, repeated start, arbitration loss or disable.
// - Bit 1 sets when either line is low and clears on stop.
// - Bit 1 keeps tracking the bus while the interface is disabled.
// - Bit 0 sets when a start has been sent as master; 0 means slave.
// - Bit 0 clears on stop, arbitration loss or interface disabled.
// - Stop flag sets in slave mode on a stop after acknowledge, not after NACK.
// - Start-sent flag sets when a start was generated in master mode.
module i2c_bus_status_tracker
  import i2c_status_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic start_generated,
  input wire logic arb_lost_event
);

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_IGNORE} link_state_t;

  // Merges a write into a 16-bit register under the low two byte lanes.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wdata,
                                          input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  // One bit of the packet check, polynomial x^8 + x^2 + x + 1.
  function automatic logic [7:0] pec_step(input logic [7:0] crc, input logic bit_in);
    logic fb;
    fb = crc[7] ^ bit_in;
    return fb ? ({crc[6:0], 1'b0} ^ PEC_POLY) : {crc[6:0], 1'b0};
  endfunction

  line_events_t ev;
  link_state_t state_q, state_d;
  logic [4:0] ctrl_q;
  logic [15:0] own_addr_q, divider_q;
  logic [3:0] evt_status_q, evt_mask_q;
  logic [31:0] readdata_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q, pec_q;
  logic ack_q, last_ack_q, ack_drive_q;
  logic start_sent_q, stop_detected_q, arb_lost_q;
  logic second_addr_q, smb_host_q, smb_default_q, general_call_q;
  logic transmit_q, busy_q, master_q;
  i2c_line_monitor u_line_monitor (
    .clock(clock),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .events(ev)
  );

  // Control fields.
  wire enable = ctrl_q[CTRL_ENABLE];
  wire pec_calc_enable = ctrl_q[CTRL_PEC_CALC_ENABLE];
  wire smb_host_type = ctrl_q[CTRL_SMB_HOST_TYPE];
  wire addr_resolution_enable = ctrl_q[CTRL_ADDR_RESOLUTION_ENABLE];
  wire general_call_enable = ctrl_q[CTRL_GENERAL_CALL_ENABLE];
  wire [6:0] own_address_first = own_addr_q[OWN_FIRST_LSB +: 7];
  wire [6:0] own_address_second = own_addr_q[OWN_SECOND_LSB +: 7];
  wire second_enable = own_addr_q[OWN_SECOND_ENABLE];

  // Bus handshake: one wait cycle, then the request is taken.
  wire request = avs_read | avs_write;
  wire accept = request & ack_q;
  wire wr_accept = accept & avs_write;
  wire rd_accept = accept & avs_read;
  assign avs_waitrequest = request & ~ack_q;
  assign avs_readdata = readdata_q;

  // Address decoding.
  wire sel_ctrl = avs_address == CTRL_OFS;
  wire sel_own = avs_address == OWN_ADDR_OFS;
  wire sel_evt = avs_address == EVT_STATUS_OFS;
  wire sel_mask = avs_address == EVT_MASK_OFS;
  wire sel_link = avs_address == LINK_STATE_OFS;
  wire sel_sts2 = avs_address == BUS_STATUS_SECOND_OFS;
  wire sel_div = avs_address == SERIAL_CLOCK_DIVIDER_OFS;

  // Address byte decoding, valid once eight bits have been shifted in.
  wire [6:0] rx_addr = shift_q[7:1];
  wire rx_rw = shift_q[0];
  wire byte_full = bit_cnt_q == BITS_PER_BYTE;
  wire hit_first = rx_addr == own_address_first;
  wire hit_second = second_enable & (rx_addr == own_address_second);
  wire hit_host = smb_host_type & addr_resolution_enable & (rx_addr == SMB_HOST_ADDR);
  wire hit_default = addr_resolution_enable & (rx_addr == SMB_DEFAULT_ADDR);
  wire hit_gc = general_call_enable & (rx_addr == GENERAL_CALL_ADDR) & ~rx_rw;
  wire addr_hit = enable & ~master_q & (hit_first | hit_second | hit_host | hit_default | hit_gc);
  wire data_bit_rise = ev.scl_rise & ~byte_full & ((state_q == ST_ADDR) | (state_q == ST_DATA));
  wire ack_rise = ev.scl_rise & byte_full & ((state_q == ST_ADDR) | (state_q == ST_DATA));
  wire addr_done = ack_rise & (state_q == ST_ADDR);
  wire addr_taken = addr_done & (addr_hit | master_q);

  // Conditions that end a transfer for the address flags.
  // stop, restart, disable
  wire addr_flags_clear = ev.stop_cond | ev.start_cond | ~enable;
  wire direction_clear = ev.stop_cond | ev.start_cond | arb_lost_event | ~enable;
  wire role_clear = ev.stop_cond | arb_lost_event | ~enable;
  wire stop_seen = ev.stop_cond & ~master_q & (state_q == ST_DATA) & last_ack_q & enable;
  wire start_seen = start_generated & enable;

  // Second status register image; reserved bit 3 always reads zero.
  bus_status_second_t sts2;
  assign sts2.pec_running_value = pec_calc_enable ? pec_q : 8'h00;
  assign sts2.second_addr_matched = second_addr_q;
  assign sts2.smb_host_hdr_seen = smb_host_q;
  assign sts2.smb_default_addr_seen = smb_default_q;
  assign sts2.general_call_seen = general_call_q;
  assign sts2.reserved3 = 1'b0;
  assign sts2.transmit_direction = transmit_q;
  assign sts2.bus_busy = busy_q;
  assign sts2.master_role = master_q;

  // Events raised this cycle; they win over a read that clears them.
  wire [3:0] evt_set = {arb_lost_event & enable, start_seen, stop_seen, addr_taken & ~master_q};
  wire [2:0] link_set = {arb_lost_event & enable, stop_seen, start_seen};
  wire [2:0] link_now = {arb_lost_q, stop_detected_q, start_sent_q};

  // Read multiplexer; unmapped addresses read as zero.
  wire [31:0] read_mux =
    sel_ctrl ? {27'h0, ctrl_q} :
    sel_own ? {16'h0000, own_addr_q} :
    sel_evt ? {28'h0000000, evt_status_q} :
    sel_mask ? {28'h0000000, evt_mask_q} :
    sel_link ? {29'h0, link_now} :
    sel_sts2 ? {16'h0000, sts2} :
    sel_div ? {16'h0000, divider_q} : 32'h00000000;

  assign irq = |(evt_status_q & evt_mask_q);
  assign sda_o = 1'b0;
  assign sda_oe_n = ~ack_drive_q;

  // Bus slave: data is captured in the wait cycle and presented when taken.
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_q <= 1'b0;
      readdata_q <= 32'h00000000;
    end else begin
      ack_q <= request & ~ack_q;
      if (request & ~ack_q) begin
        readdata_q <= avs_read ? read_mux : 32'h00000000;
      end
    end
  end

  // Software registers. The divider may only change while the interface is off,
  // so a running bus never sees its timing shift mid-byte.
  // status two has no write path
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      own_addr_q <= OWN_ADDR_RESET;
      evt_mask_q <= EVT_RESET;
      divider_q <= DIVIDER_RESET;
    end else if (wr_accept) begin
      if (sel_ctrl & avs_byteenable[0]) begin
        ctrl_q <= avs_writedata[4:0];
      end
      if (sel_own) begin
        own_addr_q <= merge16(own_addr_q, avs_writedata, avs_byteenable);
      end
      if (sel_mask & avs_byteenable[0]) begin
        evt_mask_q <= avs_writedata[3:0];
      end
      if (sel_div & ~enable) begin
        divider_q <= merge16(divider_q, avs_writedata, avs_byteenable);
      end
    end
  end

  // Sticky interrupt status. A read clears only the bits it returned, so an event
  // raised during the wait cycle is kept for the next read; a new event wins.
  always_ff @(posedge clock) begin
    if (rst) begin
      evt_status_q <= EVT_RESET;
    end else begin
      evt_status_q <= (evt_status_q & ~((rd_accept & sel_evt) ? readdata_q[3:0] : 4'h0)) | evt_set;
    end
  end

  // Link flags, cleared by reading the link state or by disabling.
  always_ff @(posedge clock) begin
    if (rst) begin
      start_sent_q <= 1'b0;
      stop_detected_q <= 1'b0;
      arb_lost_q <= 1'b0;
    end else if (~enable) begin
      start_sent_q <= 1'b0;
      stop_detected_q <= 1'b0;
      arb_lost_q <= 1'b0;
    end else begin
      start_sent_q <= (start_sent_q & ~(rd_accept & sel_link & readdata_q[LINK_START_SENT])) | link_set[0];
      stop_detected_q <= (stop_detected_q & ~(rd_accept & sel_link & readdata_q[LINK_STOP_DETECTED])) | link_set[1];
      arb_lost_q <= (arb_lost_q & ~(rd_accept & sel_link & readdata_q[LINK_ARB_LOST])) | link_set[2];
    end
  end

  // Transfer sequencer: a start opens the address phase, the ninth clock
  // closes it, and a byte nobody claims leaves the slave ignoring the rest.
  always_comb begin
    state_d = state_q;
    if (~enable | ev.stop_cond) begin
      state_d = ST_IDLE;
    end else if (ev.start_cond) begin
      state_d = ST_ADDR;
    end else if (addr_done) begin
      state_d = (addr_hit | master_q) ? ST_DATA : ST_IGNORE;
    end
  end

  // Bit counter and shifter; the ninth rising clock carries the acknowledge.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      last_ack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (ev.start_cond | ev.stop_cond) begin
        bit_cnt_q <= 4'h0;
      end else if (data_bit_rise) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        shift_q <= {shift_q[6:0], ev.sda_level};
      end else if (ack_rise) begin
        bit_cnt_q <= 4'h0;
        last_ack_q <= ~ev.sda_level;
      end
    end
  end

  // Running check value over every byte of a claimed or master transfer, address included.
  always_ff @(posedge clock) begin
    if (rst) begin
      pec_q <= 8'h00;
    end else if (~pec_calc_enable | ev.start_cond) begin
      pec_q <= 8'h00;
    end else if (data_bit_rise) begin
      pec_q <= pec_step(pec_q, ev.sda_level);
    end
  end

  // Acknowledge drive: pull the data line low from the falling clock after
  // bit eight until the falling clock after the acknowledge bit. Data bytes
  // are acknowledged only while receiving; a transmitting slave stays off
  // the line since this block has no data path of its own.
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_drive_q <= 1'b0;
    end else if (~enable | ev.start_cond | ev.stop_cond) begin
      ack_drive_q <= 1'b0;
    end else if (ev.scl_fall) begin
      if (byte_full & (state_q == ST_ADDR)) begin
        ack_drive_q <= addr_hit;
      end else if (byte_full & (state_q == ST_DATA)) begin
        ack_drive_q <= ~master_q & ~transmit_q;
      end else begin
        ack_drive_q <= 1'b0;
      end
    end
  end

  // Address-match flags, set when the address phase completes.
  always_ff @(posedge clock) begin
    if (rst) begin
      second_addr_q <= 1'b0;
      smb_host_q <= 1'b0;
      smb_default_q <= 1'b0;
      general_call_q <= 1'b0;
    end else if (addr_flags_clear) begin
      second_addr_q <= 1'b0;
      smb_host_q <= 1'b0;
      smb_default_q <= 1'b0;
      general_call_q <= 1'b0;
    end else if (addr_taken & ~master_q) begin
      second_addr_q <= hit_second & ~hit_first;
      smb_host_q <= hit_host;
      smb_default_q <= hit_default;
      general_call_q <= hit_gc;
    end
  end

  // Direction: a slave transmits on a read; a master transmits on a write.
  always_ff @(posedge clock) begin
    if (rst) begin
      transmit_q <= 1'b0;
    end else if (direction_clear) begin
      transmit_q <= 1'b0;
    end else if (addr_taken) begin
      transmit_q <= master_q ? ~rx_rw : rx_rw;
    end
  end

  // Bus busy runs regardless of the enable so software sees traffic even
  // while the interface is off.
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (ev.stop_cond) begin
      busy_q <= 1'b0;
    end else if (~ev.scl_level | ~ev.sda_level) begin
      busy_q <= 1'b1;
    end
  end

  // Master role sets on the same start as the start-sent flag; clearing terms take priority
  // only over the held value, so a start in the same cycle still sets it.
  always_ff @(posedge clock) begin
    if (rst) begin
      master_q <= 1'b0;
    end else if (start_seen) begin
      master_q <= 1'b1;
    end else if (role_clear) begin
      master_q <= 1'b0;
    end
  end

endmodule

// [core/i2c_line_monitor.sv]
module i2c_line_monitor
  import i2c_status_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output line_events_t events
);

  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;

  // Two stages per line; the first stage is read only by the second.
  always_ff @(posedge clock) begin
    if (rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // Edges and conditions come from the settled stage and its delayed copy.
  assign events.scl_level = scl_sync_q[1];
  assign events.sda_level = sda_sync_q[1];
  assign events.scl_rise = scl_sync_q[1] & ~scl_prev_q;
  assign events.scl_fall = ~scl_sync_q[1] & scl_prev_q;
  assign events.start_cond = scl_sync_q[1] & scl_prev_q & ~sda_sync_q[1] & sda_prev_q;
  assign events.stop_cond = scl_sync_q[1] & scl_prev_q & sda_sync_q[1] & ~sda_prev_q;

endmodule

// [core/i2c_status_pkg.sv]
package i2c_status_pkg;

  // Byte addresses on the register bus.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OWN_ADDR_OFS = 8'h04;
  localparam logic [7:0] EVT_STATUS_OFS = 8'h08;
  localparam logic [7:0] EVT_MASK_OFS = 8'h0C;
  localparam logic [7:0] LINK_STATE_OFS = 8'h10;
  localparam logic [7:0] BUS_STATUS_SECOND_OFS = 8'h18;
  localparam logic [7:0] SERIAL_CLOCK_DIVIDER_OFS = 8'h1C;

  // Values after reset.
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [15:0] OWN_ADDR_RESET = 16'h0000;
  localparam logic [3:0] EVT_RESET = 4'h0;
  localparam logic [15:0] STATUS_SECOND_RESET = 16'h0000;
  localparam logic [15:0] DIVIDER_RESET = 16'h0000;

  // Control register fields.
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_PEC_CALC_ENABLE = 1;
  localparam int CTRL_SMB_HOST_TYPE = 2;
  localparam int CTRL_ADDR_RESOLUTION_ENABLE = 3;
  localparam int CTRL_GENERAL_CALL_ENABLE = 4;

  // Own address register fields.
  localparam int OWN_FIRST_LSB = 0;
  localparam int OWN_SECOND_LSB = 8;
  localparam int OWN_SECOND_ENABLE = 15;

  // Sticky event bits, shared by status and mask.
  localparam int EVT_ADDR_MATCH = 0;
  localparam int EVT_STOP = 1;
  localparam int EVT_START = 2;
  localparam int EVT_ARB_LOST = 3;

  // Link state register fields.
  localparam int LINK_START_SENT = 0;
  localparam int LINK_STOP_DETECTED = 1;
  localparam int LINK_ARB_LOST = 2;

  // Reserved addresses that the slave recognises, then the check polynomial and the byte length.
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [6:0] SMB_HOST_ADDR = 7'h08;
  localparam logic [6:0] SMB_DEFAULT_ADDR = 7'h61;
  localparam logic [7:0] PEC_POLY = 8'h07;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Clock rates.
  localparam int CLOCK_HZ = 50_000_000;
  localparam int FAST_MODE_STEP_HZ = 10_000_000;

  // Field layout of the second status register.
  typedef struct packed {
    logic [7:0] pec_running_value;
    logic second_addr_matched;
    logic smb_host_hdr_seen;
    logic smb_default_addr_seen;
    logic general_call_seen;
    logic reserved3;
    logic transmit_direction;
    logic bus_busy;
    logic master_role;
  } bus_status_second_t;

  // Conditions found on the two bus lines.
  typedef struct packed {
    logic scl_level;
    logic sda_level;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
  } line_events_t;

endpackage

// [verif/i2c_master_model.sv]
module i2c_master_model (
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // Both lines released at start; the pull-ups hold them high.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Start or repeated start: data falls while the clock is high.
  task automatic start_cond();
    #3 sda_low = 1'b0;
    #40 scl = 1'b1;
    #80 sda_low = 1'b1;
    #80 scl = 1'b0;
  endtask
  // Byte goes out MSB first; the ninth clock samples the acknowledge.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #43 sda_low = !b[i];
      #37 scl = 1'b1;
      #80 scl = 1'b0;
    end
    #43 sda_low = 1'b0;
    #37 scl = 1'b1;
    #40 ack = !sda_line;
    #40 scl = 1'b0;
  endtask
  // Stop: data rises while the clock is high; the clock then stands still.
  task automatic stop_cond();
    #43 sda_low = 1'b1;
    #37 scl = 1'b1;
    #80 sda_low = 1'b0;
  endtask
endmodule

// [verif/i2c_status_checker.sv]
module i2c_status_checker
  import i2c_status_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic start_generated,
  input wire logic arb_lost_event
);
  timeunit 1ns;
  timeprecision 1ns;
  logic en_q, pec_q, sda_q, busy_q, master_q;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Bus decodes seen from outside.
  wire rd_done = avs_read && !avs_waitrequest;
  wire wr_ctrl = avs_write && !avs_waitrequest && avs_address == CTRL_OFS;
  wire st_rd = rd_done && avs_address == BUS_STATUS_SECOND_OFS;
  wire stop_raw = scl_i && sda_i && !sda_q;
  // Shadow state follows the raw pins; it is compared on every status-two read, whether or not the lines are quiet.
  always_ff @(posedge clock) begin
    if (rst) begin
      en_q <= 1'b0;
      pec_q <= 1'b0;
      sda_q <= 1'b1;
      busy_q <= 1'b0;
      master_q <= 1'b0;
    end else begin
      sda_q <= sda_i;
      if (wr_ctrl) begin
        en_q <= avs_writedata[CTRL_ENABLE];
        pec_q <= avs_writedata[CTRL_PEC_CALC_ENABLE];
      end
      if (!scl_i || !sda_i) busy_q <= 1'b1;
      else if (stop_raw) busy_q <= 1'b0;
      if (!en_q) master_q <= 1'b0;
      else if (start_generated) master_q <= 1'b1;
      else if (arb_lost_event || stop_raw) master_q <= 1'b0;
    end
  end
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request held off for more than one cycle");
  idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  ack_refused_a: assert property (!sda_oe_n |-> en_q && !master_q)
    else $error("data line driven while disabled or master");
  ack_clock_low_a: assert property ($fell(sda_oe_n) |-> !scl_i && !$past(scl_i, 2))
    else $error("data line taken while clock high");
  pec_zero_a: assert property (st_rd && !pec_q |-> avs_readdata[15:8] == 8'h00)
    else $error("check value shown while checking is off");
  reserved_zero_a: assert property (st_rd |-> avs_readdata[31:16] == 16'h0000 && !avs_readdata[3])
    else $error("reserved status bits not zero");
  busy_flag_a: assert property (st_rd |-> avs_readdata[1] == busy_q)
    else $error("busy flag does not follow the lines");
  master_flag_a: assert property (st_rd |-> avs_readdata[0] == master_q)
    else $error("master flag wrong");
  cover property (irq);
  cover property ($fell(sda_oe_n));
  cover property (st_rd && master_q);
endmodule

bind i2c_bus_status_tracker i2c_status_checker chk (.clock(clock), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_n(sda_oe_n), .start_generated(start_generated), .arb_lost_event(arb_lost_event));

// [verif/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import i2c_status_pkg::*;
  logic clock, rst, avs_read, avs_write, start_generated, arb_lost_event, hit, ack;
  logic [7:0] avs_address, ab, db;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic avs_waitrequest, irq, sda_o, sda_oe_n, scl_line, sda_low;
  logic [6:0] own_f, own_s;
  logic [15:0] exp, div;
  logic [4:0] mode;
  logic [6:0] addrs [6];
  logic [7:0] offs [8] = '{CTRL_OFS, OWN_ADDR_OFS, EVT_STATUS_OFS, EVT_MASK_OFS, LINK_STATE_OFS,
    BUS_STATUS_SECOND_OFS, SERIAL_CLOCK_DIVIDER_OFS, 8'h14};
  int errors, cmp_count, seed;
  // The data line is open drain with a pull-up.
  wire sda_line = !(sda_low || (!sda_oe_n && !sda_o));
  i2c_bus_status_tracker DUT (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .scl_i(scl_line), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .start_generated(start_generated), .arb_lost_event(arb_lost_event));
  i2c_master_model link (.sda_line(sda_line), .scl(scl_line), .sda_low(sda_low));
  // bus clock at a multiple of 10 MHz
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  // One Avalon transfer; the request stands until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        errors++;
        complete_run();
      end
      @(posedge clock);
    end
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic read_chk(input logic [7:0] a, input logic [31:0] want);
    bus(1'b0, a, 32'h0);
    check(rdata, want);
  endtask
  // Lets the synchroniser and edge finder catch up with the lines.
  task automatic settle();
    repeat (8) @(posedge clock);
  endtask
  task automatic pulse(input logic arb);
    start_generated <= !arb;
    arb_lost_event <= arb;
    @(posedge clock);
    start_generated <= 1'b0;
    arb_lost_event <= 1'b0;
    settle();
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? PEC_POLY : 8'h00);
    return c;
  endfunction
  // Flags expected after the address phase; hit tells whether the block answers.
  function automatic logic [15:0] exp_status(input logic [7:0] b, input logic [4:0] c);
    logic [6:0] a;
    logic h, dflt, gc, sec;
    a = b[7:1];
    sec = a == own_s && a != own_f;
    h = c[2] && c[3] && a == SMB_HOST_ADDR;
    dflt = c[3] && a == SMB_DEFAULT_ADDR;
    gc = c[4] && a == GENERAL_CALL_ADDR && !b[0];
    hit = a == own_f || a == own_s || h || dflt || gc;
    exp_status = 16'h0002;
    if (hit) exp_status = {(c[1] ? crc8(8'h00, b) : 8'h00), sec, h, dflt, gc, 1'b0, b[0], 2'b10};
  endfunction
  initial begin
    seed = 32057;
    rst = 1'b1;
    {avs_read, avs_write, start_generated, arb_lost_event} = 4'h0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    foreach (offs[i]) read_chk(offs[i], 32'h0);
    div = 16'($random(seed));
    bus(1'b1, SERIAL_CLOCK_DIVIDER_OFS, {16'h0, div});
    bus(1'b1, CTRL_OFS, 32'h1);
    bus(1'b1, SERIAL_CLOCK_DIVIDER_OFS, {16'h0, ~div});
    read_chk(SERIAL_CLOCK_DIVIDER_OFS, {16'h0, div});
    bus(1'b1, BUS_STATUS_SECOND_OFS, 32'($random(seed)) & ~32'h8);
    read_chk(BUS_STATUS_SECOND_OFS, 32'h0);
    own_f = {2'b01, 5'($random(seed))};
    own_s = {2'b10, 5'($random(seed))};
    addrs = '{own_f, own_s, SMB_HOST_ADDR, SMB_DEFAULT_ADDR, GENERAL_CALL_ADDR, 7'h7F};
    bus(1'b1, OWN_ADDR_OFS, {16'h0, 1'b1, own_s, 1'b0, own_f});
    bus(1'b1, EVT_MASK_OFS, 32'hF);
    for (int m = 0; m < 2; m++) begin
      mode = m ? 5'h01 : 5'h1F;
      bus(1'b1, CTRL_OFS, {27'h0, mode});
      for (int k = 0; k < 6; k++) begin
        ab = {addrs[k], (k == 0 || k == 4) ? 1'b0 : 1'($random(seed))};
        exp = exp_status(ab, mode);
        link.start_cond();
        link.send_byte(ab, ack);
        settle();
        check({31'h0, ack}, {31'h0, hit});
        if (hit) begin
          read_chk(BUS_STATUS_SECOND_OFS, {16'h0, exp});
          check({31'h0, irq}, 32'h1);
          bus(1'b0, EVT_STATUS_OFS, 32'h0);
          check({30'h0, rdata[EVT_ADDR_MATCH], irq}, 32'h2);
        end else begin
          bus(1'b0, BUS_STATUS_SECOND_OFS, 32'h0);
          check(rdata[7:0], exp[7:0]);
        end
        if (k == 0) begin
          db = 8'($random(seed));
          link.send_byte(db, ack);
          settle();
          exp[15:8] = mode[1] ? crc8(crc8(8'h00, ab), db) : 8'h00;
          read_chk(BUS_STATUS_SECOND_OFS, {16'h0, exp});
        end
        if (k[0]) begin
          link.start_cond();
          settle();
          read_chk(BUS_STATUS_SECOND_OFS, 32'h2);
        end else begin
          link.stop_cond();
          settle();
          bus(1'b0, BUS_STATUS_SECOND_OFS, 32'h0);
          check(rdata[7:0], 8'h00);
        end
        // A stop ends an acknowledged transfer only when the address was claimed.
        if (!k[0]) begin
          bus(1'b0, LINK_STATE_OFS, 32'h0);
          check(rdata[LINK_STOP_DETECTED], hit);
          bus(1'b0, EVT_STATUS_OFS, 32'h0);
          check(rdata[EVT_STOP], hit);
        end
      end
    end
    link.stop_cond();
    link.start_cond();
    link.send_byte({own_f, 1'b1}, ack);
    settle();
    bus(1'b1, CTRL_OFS, 32'h0);
    read_chk(BUS_STATUS_SECOND_OFS, 32'h2);
    link.stop_cond();
    settle();
    read_chk(BUS_STATUS_SECOND_OFS, 32'h0);
    bus(1'b1, CTRL_OFS, 32'h1);
    bus(1'b0, EVT_STATUS_OFS, 32'h0);
    pulse(1'b0);
    read_chk(LINK_STATE_OFS, 32'h1);
    read_chk(BUS_STATUS_SECOND_OFS, 32'h1);
    check({31'h0, irq}, 32'h1);
    read_chk(EVT_STATUS_OFS, 32'h4);
    pulse(1'b1);
    read_chk(BUS_STATUS_SECOND_OFS, 32'h0);
    read_chk(LINK_STATE_OFS, 32'h4);
    read_chk(EVT_STATUS_OFS, 32'h8);
    bus(1'b1, EVT_MASK_OFS, 32'h0);
    pulse(1'b0);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, CTRL_OFS, 32'h0);
    read_chk(BUS_STATUS_SECOND_OFS, 32'h0);
    read_chk(EVT_STATUS_OFS, 32'h4);
    complete_run();
  end
endmodule
